// *** core/sma_pkg.sv ***
// Package: register map, reset values, field positions and carriers
package sma_pkg;
  // Register indices; byte address is four times the index
  localparam logic [5:0] IDX_GAIN   = 6'h15; // Monitor gain code
  localparam logic [5:0] IDX_RSV_A  = 6'h16; // reserved_cfg_a
  localparam logic [5:0] IDX_CTRL0  = 6'h17; // monitor_control_main
  localparam logic [5:0] IDX_CTRL1  = 6'h18; // monitor_control_gain
  localparam logic [5:0] IDX_V0LIM  = 6'h19; // pin0_voltage_limits
  localparam logic [5:0] IDX_V1LIM  = 6'h1a; // pin1_voltage_limits
  localparam logic [5:0] IDX_TLIM   = 6'h1b; // temperature_limits
  localparam logic [5:0] IDX_CSIEN  = 6'h1c; // camera_link_alarm_enables
  localparam logic [5:0] IDX_MONEN  = 6'h1d; // monitor_alarm_enables
  localparam logic [5:0] IDX_BCEN   = 6'h1e; // return_path_alarm_enables
  localparam logic [5:0] IDX_RSV_B  = 6'h1f; // reserved_cfg_b
  localparam logic [5:0] IDX_POL    = 6'h20; // Lane polarity select
  localparam logic [5:0] IDX_STAT   = 6'h3f; // Monitor status flags
  // Reset values
  localparam logic [7:0] RST_GAIN   = 8'h20;
  localparam logic [7:0] RST_RSV_A  = 8'h18;
  localparam logic [7:0] RST_CTRL0  = 8'h0c;
  localparam logic [7:0] RST_CTRL1  = 8'h80;
  localparam logic [7:0] RST_LIM    = 8'h62;
  localparam logic [7:0] RST_CSIEN  = 8'h3f;
  localparam logic [7:0] RST_MONEN  = 8'h00;
  localparam logic [7:0] RST_BCEN   = 8'h00;
  localparam logic [7:0] RST_RSV_B  = 8'h00;
  localparam logic [7:0] RST_POL    = 8'h00;
  // Field positions and masks
  localparam int         PWR_LSB    = 2;     // Monitor power field 3:2
  localparam logic [1:0] PWR_ON     = 2'h3;  // Monitors enabled
  localparam int         GAIN_BIT   = 7;     // Gain apply bit
  localparam int         HI_LSB     = 4;     // Upper limit 6:4
  localparam int         LO_LSB     = 0;     // Lower limit 2:0
  localparam logic [7:0] POL_MASK   = 8'h1f; // Writable polarity bits
  localparam logic [7:0] GAIN_MASK  = 8'h7f; // Gain code bits
  // Status bit positions (same layout as the monitor enables)
  localparam int         ST_T_HI    = 5;
  localparam int         ST_T_LO    = 4;
  localparam int         ST_V1_HI   = 3;
  localparam int         ST_V1_LO   = 2;
  localparam int         ST_V0_HI   = 1;
  localparam int         ST_V0_LO   = 0;

  // One monitor sample, quantised like the limits
  typedef struct packed {
    logic       valid;
    logic [2:0] v0;
    logic [2:0] v1;
    logic [2:0] t;
  } sma_sample_t;

  // Raw link events: camera input and return path
  typedef struct packed {
    logic [5:0] csi;
    logic [1:0] bc;
  } sma_events_t;

  // Gated alarm outputs
  typedef struct packed {
    logic [5:0] mon;
    logic [5:0] csi;
    logic [1:0] bc;
  } sma_alarms_t;

  // Whole state of the register bank
  typedef struct packed {
    logic [7:0]  gain;
    logic [7:0]  rsv_a;
    logic [7:0]  ctrl0;
    logic [7:0]  ctrl1;
    logic [7:0]  v0lim;
    logic [7:0]  v1lim;
    logic [7:0]  tlim;
    logic [7:0]  csien;
    logic [7:0]  monen;
    logic [7:0]  bcen;
    logic [7:0]  rsv_b;
    logic [7:0]  pol;
    logic [5:0]  status;
    logic [31:0] prdata;
    logic        err;
    sma_alarms_t alarms;
  } sma_state_t;
endpackage : sma_pkg

// *** core/sma_regbank.sv ***
// Monitor limit and alarm enable register bank with APB slave
`timescale 1ns/1ns
module sma_regbank
  import sma_pkg::*;
(
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // Monitor samples and link events
  input  sma_sample_t      sample,
  input  sma_events_t      events,
  // Monitor configuration
  output logic [1:0]       mon_power,
  output logic [1:0]       pin_select,
  output logic             gain_apply,
  output logic [6:0]       monitor_gain_code,
  output logic [4:0]       lane_polarity,
  // Gated alarms
  output sma_alarms_t      alarms
);

  sma_state_t s_r;      // Registered state
  sma_state_t s_nxt;    // Next state
  logic       setup;    // APB setup cycle
  logic       wr_acc;   // APB write access phase
  logic       hit;      // Address maps to a register
  logic [5:0] idx;      // Register index
  logic [5:0] set_v;    // Limit crossings this cycle
  logic [5:0] clr_v;    // Software clears this cycle

  // Mapped index check, aligned words only
  // Only word-aligned accesses to a known index are accepted; anything else
  // answers with an error, so a stray pointer cannot alter the bank.
  // The status word sits apart from the configuration block at the top index.
  function automatic logic is_mapped(input logic [7:0] a);
    logic [5:0] i;
    i = a[7:2];
    is_mapped = (a[1:0] == 2'h0) &&
                (((i >= IDX_GAIN) && (i <= IDX_POL)) || (i == IDX_STAT));
  endfunction : is_mapped

  // Read multiplexer, narrow registers in the low byte
  // Registers are eight bits wide; the upper bytes of the bus read as zero.
  // The value is taken from the registered state, never from bus inputs,
  // so read data cannot ripple while the access phase is open.
  function automatic logic [7:0] rd_val(input sma_state_t s, input logic [5:0] i);
    rd_val = 8'h00;
    case (i)
      IDX_GAIN:  rd_val = s.gain;
      IDX_RSV_A: rd_val = s.rsv_a;
      IDX_CTRL0: rd_val = s.ctrl0;
      IDX_CTRL1: rd_val = s.ctrl1;
      IDX_V0LIM: rd_val = s.v0lim;
      IDX_V1LIM: rd_val = s.v1lim;
      IDX_TLIM:  rd_val = s.tlim;
      IDX_CSIEN: rd_val = s.csien;
      IDX_MONEN: rd_val = s.monen;
      IDX_BCEN:  rd_val = s.bcen;
      IDX_RSV_B: rd_val = s.rsv_b;
      IDX_POL:   rd_val = s.pol;
      IDX_STAT:  rd_val = {2'h0, s.status};
      default:   rd_val = 8'h00;
    endcase
  endfunction : rd_val

  // Bus decode
  // Address and direction are held by the master from setup to access,
  // so the same decode serves both phases of a transfer.
  assign setup  = psel & ~penable;
  assign wr_acc = psel & penable & pwrite;
  assign idx    = paddr[7:2];
  assign hit    = is_mapped(paddr);

  // Zero wait states; error flag was caught in the setup cycle
  // Every transfer therefore takes exactly two cycles; a master that
  // waits for ready still works, it simply never sees a wait state.
  assign pready  = psel & penable;
  assign pslverr = psel & penable & s_r.err;
  assign prdata  = s_r.prdata;

  // Limit comparisons on each new sample
  // Compares are strict and unsigned: a reading equal to a limit is in range.
  // Nothing is compared between samples, so stale sensor fields between
  // pulses can never raise a flag.
  // Voltage channels follow only the pin select; temperature needs the
  // power field fully on, the two mixed codes count as off.
  always_comb
  begin
    set_v = 6'h00;
    if (sample.valid)
    begin
      // Voltage checks follow the pin select bits
      if (s_r.ctrl0[0])
      begin
        set_v[ST_V0_HI] = sample.v0 > s_r.v0lim[HI_LSB +: 3];
        set_v[ST_V0_LO] = sample.v0 < s_r.v0lim[LO_LSB +: 3];
      end
      if (s_r.ctrl0[1])
      begin
        set_v[ST_V1_HI] = sample.v1 > s_r.v1lim[HI_LSB +: 3];
        set_v[ST_V1_LO] = sample.v1 < s_r.v1lim[LO_LSB +: 3];
      end
      // Temperature checks only while the monitors are on
      if (s_r.ctrl0[PWR_LSB +: 2] == PWR_ON)
      begin
        set_v[ST_T_HI] = sample.t > s_r.tlim[HI_LSB +: 3];
        set_v[ST_T_LO] = sample.t < s_r.tlim[LO_LSB +: 3];
      end
    end
  end

  // Write-one-to-clear strobe for the status flags
  // A zero bit in the written word leaves its flag alone, so software can
  // acknowledge one condition without losing another.
  assign clr_v = (wr_acc && hit && (idx == IDX_STAT)) ? pwdata[5:0] : 6'h00;

  // Next state: bus writes, read capture, flags and alarms
  // Read data is latched in the setup cycle and then stands for the whole
  // access phase; a write lands only at the access edge.
  // Alarms are registered so their outputs are glitch free.
  always_comb
  begin
    s_nxt = s_r;
    // Capture read data and error in the setup cycle
    if (setup)
    begin
      s_nxt.prdata = (hit && !pwrite) ? {24'h0, rd_val(s_r, idx)} : 32'h0;
      s_nxt.err    = ~hit;
    end
    // Writes take effect at the access edge
    if (wr_acc && hit)
    begin
      case (idx)
        IDX_GAIN:  s_nxt.gain  = pwdata[7:0];
        IDX_RSV_A: s_nxt.rsv_a = pwdata[7:0];
        IDX_CTRL0: s_nxt.ctrl0 = pwdata[7:0];
        IDX_CTRL1: s_nxt.ctrl1 = pwdata[7:0];
        IDX_V0LIM: s_nxt.v0lim = pwdata[7:0];
        IDX_V1LIM: s_nxt.v1lim = pwdata[7:0];
        IDX_TLIM:  s_nxt.tlim  = pwdata[7:0];
        IDX_CSIEN: s_nxt.csien = pwdata[7:0];
        IDX_MONEN: s_nxt.monen = pwdata[7:0];
        IDX_BCEN:  s_nxt.bcen  = pwdata[7:0];
        IDX_RSV_B: s_nxt.rsv_b = pwdata[7:0];
        IDX_POL:   s_nxt.pol   = pwdata[7:0] & POL_MASK;
        default:   s_nxt.gain  = s_r.gain;
      endcase
    end
    // Flags record regardless of enables; set beats clear
    s_nxt.status = (s_r.status & ~clr_v) | set_v;
    // Monitor alarms gated by their enables
    s_nxt.alarms.mon = s_r.status & s_r.monen[5:0];
    // Camera link alarms gated bit by bit
    s_nxt.alarms.csi = events.csi & s_r.csien[5:0];
    // Return path alarms
    s_nxt.alarms.bc  = events.bc & s_r.bcen[1:0];
  end

  // State register
  // Reset loads constants only; the whole bank comes back to its defaults
  // with the monitors powered and every monitor alarm masked.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_r        <= '0;
      s_r.gain   <= RST_GAIN;
      s_r.rsv_a  <= RST_RSV_A;
      s_r.ctrl0  <= RST_CTRL0;
      s_r.ctrl1  <= RST_CTRL1;
      s_r.v0lim  <= RST_LIM;
      s_r.v1lim  <= RST_LIM;
      s_r.tlim   <= RST_LIM;
      s_r.csien  <= RST_CSIEN;
      s_r.monen  <= RST_MONEN;
      s_r.bcen   <= RST_BCEN;
      s_r.rsv_b  <= RST_RSV_B;
      s_r.pol    <= RST_POL;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  // Configuration outputs straight from flops
  // The analog side sees a new setting straight after the write edge, with no extra cycle.
  assign mon_power         = s_r.ctrl0[PWR_LSB +: 2];
  assign pin_select        = s_r.ctrl0[1:0];
  assign gain_apply        = s_r.ctrl1[GAIN_BIT];
  assign monitor_gain_code = s_r.gain[6:0];
  assign lane_polarity     = s_r.pol[4:0];
  assign alarms            = s_r.alarms;

  // Checks
  // All checks run on the bus clock and are silenced while in reset.
  // Each one watches registered state and outputs; all but four also watch the bus, sample or event inputs.
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_pin0_over_set: assert property (
    sample.valid && s_r.ctrl0[0] && (sample.v0 > s_r.v0lim[6:4]) |=> s_r.status[1])
    else $error("pin0 over flag not set");
  a_pin0_under_set: assert property (
    sample.valid && s_r.ctrl0[0] && (sample.v0 < s_r.v0lim[2:0]) |=> s_r.status[0])
    else $error("pin0 under flag not set");
  a_pin1_over_set: assert property (
    sample.valid && s_r.ctrl0[1] && (sample.v1 > s_r.v1lim[6:4]) |=> s_r.status[3])
    else $error("pin1 over flag not set");
  a_pin1_under_set: assert property (
    sample.valid && s_r.ctrl0[1] && (sample.v1 < s_r.v1lim[2:0]) |=> s_r.status[2])
    else $error("pin1 under flag not set");
  a_temp_over_set: assert property (
    sample.valid && (s_r.ctrl0[3:2] == 2'h3) && (sample.t > s_r.tlim[6:4])
    |=> s_r.status[5])
    else $error("temperature over flag not set");
  a_temp_under_set: assert property (
    sample.valid && (s_r.ctrl0[3:2] == 2'h3) && (sample.t < s_r.tlim[2:0])
    |=> s_r.status[4])
    else $error("temperature under flag not set");
  a_temp_off_quiet: assert property (
    (s_r.ctrl0[3:2] != 2'h3) && !s_r.status[5] && !(wr_acc && idx == 6'h17)
    |=> !s_r.status[5])
    else $error("temperature flag set while monitors off");
  a_flag_sticky: assert property (
    s_r.status[1] && !clr_v[1] |=> s_r.status[1])
    else $error("status flag lost without clear");
  a_mon_alarm_gate: assert property (
    ##1 alarms.mon == $past(s_r.status & s_r.monen[5:0]))
    else $error("monitor alarm not gated by enable");
  a_csi_alarm_gate: assert property (
    ##1 alarms.csi == $past(events.csi & s_r.csien[5:0]))
    else $error("camera alarm not gated by enable");
  a_bc_alarm_gate: assert property (
    events.bc[1] && !s_r.bcen[1] |=> !alarms.bc[1])
    else $error("return path alarm passed while disabled");

  // Gain code written over the bus shows at the output
  a_gain_write_lands: assert property (
    wr_acc && hit && (idx == IDX_GAIN)
    |=> monitor_gain_code == $past(pwdata[6:0]))
    else $error("gain code write lost");

  // Power field written over the bus shows at the output
  a_power_write_lands: assert property (
    wr_acc && hit && (idx == IDX_CTRL0)
    |=> mon_power == $past(pwdata[3:2]))
    else $error("power field write lost");

  // Pin select written over the bus shows at the output
  a_pinsel_write_lands: assert property (
    wr_acc && hit && (idx == IDX_CTRL0)
    |=> pin_select == $past(pwdata[1:0]))
    else $error("pin select write lost");

  // Gain apply bit written over the bus shows at the output
  a_apply_write_lands: assert property (
    wr_acc && hit && (idx == IDX_CTRL1)
    |=> gain_apply == $past(pwdata[7]))
    else $error("gain apply write lost");

  // Lane polarity written over the bus shows at the output
  a_pol_write_lands: assert property (
    wr_acc && hit && (idx == IDX_POL)
    |=> lane_polarity == $past(pwdata[4:0]))
    else $error("polarity write lost");

  // Unused polarity bits never store a one
  a_pol_top_zero: assert property (
    wr_acc && hit && (idx == IDX_POL)
    |=> s_r.pol[7:5] == 3'h0)
    else $error("polarity spare bits stored");

  // Pin 0 not selected: its under flag cannot rise
  a_pin0_off_quiet: assert property (
    !s_r.ctrl0[0] && !s_r.status[0]
    |=> !s_r.status[0])
    else $error("pin0 flag set while not selected");

  // Pin 1 not selected: its over flag cannot rise
  a_pin1_off_quiet: assert property (
    !s_r.ctrl0[1] && !s_r.status[3]
    |=> !s_r.status[3])
    else $error("pin1 flag set while not selected");

  // A crossing in the same cycle as a clear keeps the flag
  a_set_beats_clear: assert property (
    set_v[0] && clr_v[0]
    |=> s_r.status[0])
    else $error("clear beat a new crossing");

  // A clear with no new crossing drops the flag
  a_clear_drops: assert property (
    clr_v[5] && !set_v[5]
    |=> !s_r.status[5])
    else $error("status flag not cleared");

  // Flags only rise on a sample pulse
  a_flag_needs_sample: assert property (
    !sample.valid && !s_r.status[4]
    |=> !s_r.status[4])
    else $error("flag set without a sample");

  // Length error alarm blocked while disabled
  a_len_alarm_gate: assert property (
    events.csi[0] && !s_r.csien[0]
    |=> !alarms.csi[0])
    else $error("length alarm passed while disabled");

  // Missing frame alarm passes while enabled
  a_frame_alarm_pass: assert property (
    events.csi[5] && s_r.csien[5]
    |=> alarms.csi[5])
    else $error("missing frame alarm not passed");

  // Link detect alarm passes while enabled
  a_link_alarm_pass: assert property (
    events.bc[0] && s_r.bcen[0]
    |=> alarms.bc[0])
    else $error("link detect alarm not passed");

  // Pin 0 under alarm silent while its enable is clear
  a_pin0_alarm_off: assert property (
    !s_r.monen[0]
    |=> !alarms.mon[0])
    else $error("pin0 alarm passed while disabled");

  // Refused accesses answer with an error
  a_refused_error: assert property (
    psel && penable && !is_mapped(paddr)
    |-> pslverr)
    else $error("refused access gave no error");

endmodule : sma_regbank

// *** dv/sma_sensor_model.sv ***
// Behavioural on-chip sensor and link event source feeding the register bank
`timescale 1ns/1ns
module sma_sensor_model
  import sma_pkg::*;
(
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Commands from the bench
  input  wire logic       fire,
  input  wire logic [8:0] level,
  input  sma_events_t     ev_in,
  // Toward the bank
  output sma_sample_t     sample,
  output sma_events_t     events
);
  // One-cycle sample pulse; fields flip between samples so stale data never looks steady
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sample <= '0;
      events <= '0;
    end
    else
    begin
      sample <= fire ? {1'b1, level} : {1'b0, ~sample[8:0]};
      events <= ev_in;
    end
  end
endmodule : sma_sensor_model

// *** dv/sma_regbank_test.sv ***
// Self-checking bench for the monitor limit and alarm enable register bank
`timescale 1ns/1ns
`define CHK(what, exp, got) begin samples_checked++; if ((got) !== (exp)) begin bad_count++; \
  $display("[FAIL] %s expected %0h seen %0h", what, exp, got); end end
module sma_regbank_test;
  import sma_pkg::*;
  typedef struct packed { logic [5:0] idx; logic [7:0] rst, wr, exp; } sma_row_t;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, fire = 0;
  logic [7:0]  paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic        pready, pslverr, gain_apply, err;
  logic [1:0]  mon_power, pin_select;
  logic [6:0]  monitor_gain_code;
  logic [4:0]  lane_polarity;
  logic [8:0]  level = '0;
  sma_events_t ev_in = '0, events;
  sma_sample_t sample;
  sma_alarms_t alarms;
  int          bad_count = 0, samples_checked = 0;
  // Register table: index, reset value, value written, value read back
  sma_row_t rows [12] = '{
    '{IDX_GAIN, RST_GAIN, 8'h95, 8'h95}, '{IDX_RSV_A, RST_RSV_A, 8'ha5, 8'ha5},
    '{IDX_CTRL0, RST_CTRL0, 8'h5a, 8'h5a}, '{IDX_CTRL1, RST_CTRL1, 8'h3c, 8'h3c},
    '{IDX_V0LIM, RST_LIM, 8'h71, 8'h71}, '{IDX_V1LIM, RST_LIM, 8'h17, 8'h17},
    '{IDX_TLIM, RST_LIM, 8'h53, 8'h53}, '{IDX_CSIEN, RST_CSIEN, 8'h2a, 8'h2a},
    '{IDX_MONEN, RST_MONEN, 8'h15, 8'h15}, '{IDX_BCEN, RST_BCEN, 8'h02, 8'h02},
    '{IDX_RSV_B, RST_RSV_B, 8'hc3, 8'hc3}, '{IDX_POL, RST_POL, 8'hff, 8'h1f}};

  // Clock at 125 MHz
  always #4 pclk = ~pclk;

  sma_regbank u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .sample(sample), .events(events), .mon_power(mon_power),
    .pin_select(pin_select), .gain_apply(gain_apply),
    .monitor_gain_code(monitor_gain_code), .lane_polarity(lane_polarity), .alarms(alarms));

  sma_sensor_model u_sensor (.pclk(pclk), .presetn(presetn), .fire(fire), .level(level),
    .ev_in(ev_in), .sample(sample), .events(events));

  // Verdict and end of run
  task automatic end_of_test;
    $display("Checks %0d, mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : end_of_test

  // One APB transfer: setup, then access held until pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20)
    begin
      @(posedge pclk);
      n++;
    end
    `CHK("pready", 1'b1, pready)
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask : apb

  // Fire one sample, read the flags, then clear them by write-one
  task automatic samp(input logic [8:0] lv, input logic [7:0] exp);
    level <= lv;
    fire <= 1;
    @(posedge pclk);
    fire <= 0;
    repeat (3) @(posedge pclk);
    apb(0, {IDX_STAT, 2'b00}, 8'h00);
    `CHK("status", {24'h0, exp}, rd)
    apb(1, {IDX_STAT, 2'b00}, 8'h3f);
  endtask : samp

  // Watchdog
  initial
  begin
    #50000;
    bad_count++;
    end_of_test;
  end

  // Main sequence
  initial
  begin
    repeat (6) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    foreach (rows[i])
    begin
      apb(0, {rows[i].idx, 2'b00}, 8'h00);
      `CHK("reset value", {24'h0, rows[i].rst}, rd)
      apb(1, {rows[i].idx, 2'b00}, rows[i].wr);
      apb(0, {rows[i].idx, 2'b00}, 8'h00);
      `CHK("readback", {24'h0, rows[i].exp}, rd)
      `CHK("mapped error", 1'b0, err)
    end
    `CHK("mon_power", rows[2].wr[3:2], mon_power)
    `CHK("pin_select", rows[2].wr[1:0], pin_select)
    `CHK("gain_apply", rows[3].wr[7], gain_apply)
    `CHK("gain code", rows[0].wr[6:0], monitor_gain_code)
    `CHK("polarity", rows[11].exp[4:0], lane_polarity)
    $display("Register table test done");
    // Limits back to reset, monitors on, both pins, alarms masked
    for (int i = 0; i < 3; i++)
      apb(1, {IDX_V0LIM + 6'(i), 2'b00}, RST_LIM);
    apb(1, {IDX_CTRL0, 2'b00}, 8'h0f);
    apb(1, {IDX_MONEN, 2'b00}, 8'h00);
    samp({3'h6, 3'h2, 3'h2}, 8'h00);
    samp({3'h0, 3'h7, 3'h0}, 8'h19);
    level <= {3'h7, 3'h1, 3'h7};
    fire <= 1;
    @(posedge pclk);
    fire <= 0;
    repeat (3) @(posedge pclk);
    `CHK("masked alarms", 6'h00, alarms.mon)
    apb(1, {IDX_MONEN, 2'b00}, 8'h3f);
    repeat (2) @(posedge pclk);
    `CHK("monitor alarms", 6'h26, alarms.mon)
    apb(1, {IDX_STAT, 2'b00}, 8'h3f);
    repeat (2) @(posedge pclk);
    `CHK("cleared alarms", 6'h00, alarms.mon)
    apb(1, {IDX_CTRL0, 2'b00}, 8'h00);
    samp({3'h7, 3'h7, 3'h7}, 8'h00);
    apb(1, {IDX_CTRL0, 2'b00}, 8'h01);
    samp({3'h7, 3'h7, 3'h0}, 8'h02);
    apb(1, {IDX_CTRL0, 2'b00}, 8'h06);
    samp({3'h7, 3'h7, 3'h7}, 8'h08);
    $display("Monitor limit test done");
    // Link events through the enables
    apb(1, {IDX_CSIEN, 2'b00}, 8'h15);
    apb(1, {IDX_BCEN, 2'b00}, 8'h02);
    ev_in <= '{csi: 6'h3f, bc: 2'h3};
    repeat (3) @(posedge pclk);
    `CHK("camera alarms", 6'h15, alarms.csi)
    `CHK("return alarms", 2'h2, alarms.bc)
    $display("Event gating test done");
    // Unmapped and misaligned accesses are refused
    apb(1, 8'h40, 8'hff);
    `CHK("unmapped error", 1'b1, err)
    apb(0, 8'h40, 8'h00);
    `CHK("unmapped data", 32'h0, rd)
    apb(0, 8'h5d, 8'h00);
    `CHK("misaligned error", 1'b1, err)
    // Reset in mid-run restores defaults
    presetn <= 0;
    repeat (2) @(posedge pclk);
    `CHK("power in reset", PWR_ON, mon_power)
    `CHK("alarms in reset", 14'h0, alarms)
    presetn <= 1;
    @(posedge pclk);
    apb(0, {IDX_CSIEN, 2'b00}, 8'h00);
    `CHK("enables after reset", {24'h0, RST_CSIEN}, rd)
    $display("Refusal and reset test done");
    end_of_test;
  end
endmodule : sma_regbank_test
